// ### hdl/ess_pkg.sv
// Package for the endpoint status set/clear block: offsets, bit positions,
// type codes and the carriers to and from the USB protocol engine.
// Assumes a byte-addressed register window of 256 bytes.
package ess_pkg;

  localparam int unsigned NUM_EP = 7;
  localparam logic [31:0] BASE_ADDR = 32'hf803c100;
  localparam logic [31:0] SET_ADDR0 = 32'hf803c114;
  localparam logic [31:0] CLR_ADDR0 = 32'hf803c118;
  localparam logic [31:0] STA_ADDR0 = 32'hf803c11c;
  localparam logic [7:0] EP_STRIDE = 8'h20;
  localparam logic [4:0] OFF_CFG = 5'h10;
  localparam logic [4:0] OFF_SET = 5'(SET_ADDR0 - BASE_ADDR);
  localparam logic [4:0] OFF_CLR = 5'(CLR_ADDR0 - BASE_ADDR);
  localparam logic [4:0] OFF_STA = 5'(STA_ADDR0 - BASE_ADDR);
  localparam logic [7:0] ADDR_IRQ_STA = 8'he0;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'he4;

  localparam logic [1:0] EP_TYPE_CTRL = 2'h0;
  localparam logic [1:0] EP_TYPE_ISO = 2'h1;
  localparam logic [1:0] EP_TYPE_BULK = 2'h2;
  localparam logic [1:0] EP_TYPE_INTR = 2'h3;
  localparam int unsigned CFG_DIR_IN = 3;

  localparam int unsigned B_STALL = 5;
  localparam int unsigned B_TOGGLE = 6;
  localparam int unsigned B_OVFLW = 8;
  localparam int unsigned B_RXKL = 9;
  localparam int unsigned B_TXCMP = 10;
  localparam int unsigned B_TX_PACKET_READY = 11;
  localparam int unsigned B_SETUP = 12;
  localparam int unsigned B_STSNT = 13;
  localparam int unsigned B_NAKIN = 14;
  localparam int unsigned B_NAKOUT = 15;
  localparam int unsigned B_ISO_FLOW = 12;
  localparam int unsigned B_ISO_CRC = 13;
  localparam int unsigned B_ISO_FLUSH = 14;
  localparam int unsigned B_CURBK = 16;
  localparam int unsigned B_BUSY = 18;
  localparam int unsigned B_COUNT = 20;
  localparam int unsigned B_SHORT = 31;
  localparam logic [1:0] PID_DATA0 = 2'h0;
  localparam logic [1:0] PID_DATA1 = 2'h1;

  typedef struct packed {
    logic [1:0] ep_type;
    logic dir_in;
    logic tx_packet_ready;
    logic in_flight;
    logic rx_data_ready;
    logic tx_complete_flag;
    logic force_stall_request;
    logic [1:0] data_toggle_state;
    logic rx_setup;
    logic stall_sent;
    logic nak_in;
    logic nak_out;
    logic iso_flow_error;
    logic crc_or_trans_count_error;
    logic flush_error;
    logic overflow_error;
    logic short_packet;
    logic ctl_dir;
    logic [10:0] byte_count;
    logic [10:0] tx_len;
  } ess_ep_t;

  // One event per cycle from the protocol engine, for the endpoint ep
  typedef struct packed {
    logic valid;
    logic [2:0] ep;
    logic in_token;
    logic in_ack;
    logic in_sent;
    logic out_rx;
    logic [1:0] out_pid;
    logic [10:0] out_count;
    logic out_short;
    logic out_overflow;
    logic setup_rx;
    logic setup_dir;
    logic nak_in;
    logic nak_out;
    logic stall_sent;
    logic iso_flow;
    logic iso_crc;
    logic iso_flush;
    logic fifo_wr;
  } ess_evt_t;

  typedef struct packed {
    logic tx_start;
    logic [2:0] ep;
    logic [10:0] len;
    logic zlp;
    logic [1:0] pid;
  } ess_tx_t;

endpackage

// ### hdl/ess_top.sv
// Endpoint status set/clear logic for seven USB endpoints, with an
// Avalon-MM slave for firmware and an event/command port to the engine.
// Assumes the engine reports events synchronous to clk_in, one per cycle.
// Summary of operation
// RULE1: Set packet-ready marks the bank ready; next IN token sends it.
// RULE2: Firmware waits for packet-ready clear before loading new data.
// RULE3: Packet-ready with zero bytes written sends a zero length packet.
// RULE4: Firmware loads IN bytes through the buffer window first.
// RULE5: No IN transaction starts until packet-ready was set.
// RULE6: Non-iso endpoints flag transmit-complete when the host acks.
// RULE7: Iso endpoints flag transmit-complete once the packet is sent.
// RULE8: Set bit 9 on an IN endpoint kills the last written bank; the code leaves a bank that is already in flight.
// RULE9: Clear bit 5 withdraws a pending stall request.
// RULE10: Clear bit 6 resets the data toggle to DATA0.
// RULE11: Clear bits 9 and 10 clear received-data and transmit-complete.
// RULE12: Non-iso clear bits 12..15 clear setup, stall-sent, NAK flags.
// RULE13: Iso clear bits 12..14 clear flow, CRC, and flush errors.
// RULE14: Endpoint type 0x1 selects the iso layout, others the normal.
// RULE15: Zero bits have no effect; set and clear registers are write-only.
// RULE16: Hardware clears packet-ready once the host acked the packet.
// RULE17: A received SETUP drops a pending stall request.
// RULE18: Register group repeats for seven endpoints at a 0x20 stride.
// RULE19: Written ones act as one-cycle strobes and are never stored.
`timescale 1ns/100ps

module ess_top
  import ess_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic usb_reset_in,
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire ess_evt_t evt_in,
  output ess_tx_t tx_out,
  output logic [NUM_EP-1:0] stall_answer_out,
  output logic [NUM_EP-1:0] toggle_lsb_out,
  output logic irq_out
);

  typedef struct packed {
    ess_ep_t [NUM_EP-1:0] ep;
    logic [NUM_EP-1:0] irq_sta;
    logic [NUM_EP-1:0] irq_mask;
    logic irq;
    logic wait_q;
    logic [31:0] rdata;
    ess_tx_t tx;
    logic [NUM_EP-1:0] stall_ans;
    logic [NUM_EP-1:0] tog;
  } ess_state_t;

  ess_state_t state_reg;
  ess_state_t state_next;

  // ------------------------------------------------------------
  // Status word of one endpoint; bits 15..12 and 5 follow the type
  // ------------------------------------------------------------
  function automatic logic [31:0] sta_word(input ess_ep_t ep_st);
    logic [31:0] w;
    w = '0;
    w[B_SHORT] = ep_st.short_packet;
    w[B_COUNT +: 11] = ep_st.byte_count;
    // Single bank: the busy count is zero or one
    w[B_BUSY +: 2] = ep_st.dir_in ? {1'b0, ep_st.tx_packet_ready} :
      {1'b0, ep_st.rx_data_ready};
    w[B_CURBK +: 2] = {1'b0, ep_st.ctl_dir};
    w[B_TX_PACKET_READY] = ep_st.tx_packet_ready;
    w[B_TXCMP] = ep_st.tx_complete_flag;
    w[B_RXKL] = ep_st.rx_data_ready;
    w[B_OVFLW] = ep_st.overflow_error;
    w[7:6] = ep_st.data_toggle_state;
    if (ep_st.ep_type == EP_TYPE_ISO) begin // [RULE14]
      w[B_ISO_FLOW] = ep_st.iso_flow_error;
      w[B_ISO_CRC] = ep_st.crc_or_trans_count_error;
      w[B_ISO_FLUSH] = ep_st.flush_error;
    end else begin
      w[B_NAKOUT] = ep_st.nak_out;
      w[B_NAKIN] = ep_st.nak_in;
      w[B_STSNT] = ep_st.stall_sent;
      w[B_SETUP] = ep_st.rx_setup;
      w[B_STALL] = ep_st.force_stall_request;
    end
    return w;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    ess_ep_t e;
    logic [2:0] idx;
    logic [4:0] off;
    logic wr_go;
    logic rd_go;
    logic rd_first;
    logic sel;
    logic ev;
    logic iso;
    logic [31:0] setw;
    logic [31:0] clrw;
    logic [NUM_EP-1:0] irq_set;
    logic [NUM_EP-1:0] irq_clr;
    logic [NUM_EP-1:0] sta_next;
    logic cfg_sel;
    logic sta_sel;
    logic start_ok;
    logic done;
    logic kill_ok;
    e = '0;
    cfg_sel = 1'b0;
    sta_sel = 1'b0;
    start_ok = 1'b0;
    done = 1'b0;
    kill_ok = 1'b0;
    sta_next = '0;
    idx = address_in[7:5];
    off = address_in[4:0];
    wr_go = write_in && !state_reg.wait_q;
    rd_go = read_in && !state_reg.wait_q;
    rd_first = read_in && state_reg.wait_q;
    sel = 1'b0;
    ev = 1'b0;
    iso = 1'b0;
    setw = '0;
    clrw = '0;
    irq_set = '0;
    irq_clr = '0;
    state_next = state_reg;
    state_next.tx.tx_start = 1'b0;

    // Answer one cycle after the request: read data is latched on the
    // first edge, then waitrequest drops for exactly one cycle.
    state_next.wait_q = 1'b1;
    if ((read_in || write_in) && state_reg.wait_q) begin
      state_next.wait_q = 1'b0;
    end
    if (rd_first) begin
      state_next.rdata = '0;
      if (address_in == ADDR_IRQ_STA) begin
        state_next.rdata[NUM_EP-1:0] = state_reg.irq_sta;
      end else if (address_in == ADDR_IRQ_MASK) begin
        state_next.rdata[NUM_EP-1:0] = state_reg.irq_mask;
      end
    end
    // Mask writes act at the accepting edge, like every other write
    if (wr_go && address_in == ADDR_IRQ_MASK) begin
      state_next.irq_mask = writedata_in[NUM_EP-1:0];
    end

    // One pass per endpoint; all passes share the bus decode above
    for (int i = 0; i < NUM_EP; i++) begin
      e = state_reg.ep[i];
      iso = (e.ep_type == EP_TYPE_ISO); // [RULE14]
      sel = wr_go && (idx == 3'(i)); // [RULE18]
      ev = evt_in.valid && (evt_in.ep == 3'(i));
      // Ones are used as strobes only; zeros do nothing [RULE15] [RULE19]
      setw = (sel && off == OFF_SET) ? writedata_in : '0;
      clrw = (sel && off == OFF_CLR) ? writedata_in : '0;

      // Status and config reads; set and clear read back as zero
      cfg_sel = rd_first && idx == 3'(i) && off == OFF_CFG;
      sta_sel = rd_first && idx == 3'(i) && off == OFF_STA;
      if (cfg_sel) begin
        state_next.rdata[1:0] = e.ep_type;
        state_next.rdata[CFG_DIR_IN] = e.dir_in;
      end
      if (sta_sel) begin
        state_next.rdata = sta_word(e);
      end
      // Config steers the register layout, the IN path and the completion event
      if (sel && off == OFF_CFG) begin
        e.ep_type = writedata_in[1:0];
        e.dir_in = writedata_in[CFG_DIR_IN];
      end

      // ------------------------------------------------------------
      // Events from the engine
      // ------------------------------------------------------------
      // Bytes loaded while a bank waits are not counted into it
      if (ev && evt_in.fifo_wr && e.dir_in && !e.tx_packet_ready) begin
        e.byte_count = e.byte_count + 11'h001;
      end
      // Only a ready bank is offered to the host [RULE5]
      start_ok = ev && evt_in.in_token && e.dir_in && e.tx_packet_ready
        && !e.in_flight;
      if (start_ok) begin
        e.in_flight = 1'b1;
        state_next.tx.tx_start = 1'b1; // [RULE1]
        state_next.tx.ep = 3'(i);
        state_next.tx.len = e.tx_len;
        state_next.tx.zlp = (e.tx_len == 11'h000); // [RULE3]
        state_next.tx.pid = e.data_toggle_state;
      end
      // Completion of this cycle, kept to beat a clear of the same cycle
      done = ev && e.in_flight &&
        ((evt_in.in_ack && !iso) || (evt_in.in_sent && iso));
      if (done) begin
        e.in_flight = 1'b0;
        e.tx_packet_ready = 1'b0; // [RULE16]
        e.tx_complete_flag = 1'b1; // [RULE6] [RULE7]
        irq_set[i] = 1'b1;
        // The toggle advances only on a handshake; iso has none
        if (!iso) begin
          e.data_toggle_state = {1'b0, ~e.data_toggle_state[0]};
        end
      end
      // A new OUT packet replaces the count, toggle and error view
      if (ev && evt_in.out_rx) begin
        e.rx_data_ready = 1'b1;
        e.byte_count = evt_in.out_count;
        e.data_toggle_state = evt_in.out_pid;
        e.short_packet = evt_in.out_short;
        e.overflow_error = evt_in.out_overflow;
        irq_set[i] = 1'b1;
      end
      if (ev && evt_in.setup_rx) begin
        e.rx_setup = 1'b1;
        e.ctl_dir = evt_in.setup_dir;
        e.byte_count = evt_in.out_count;
        irq_set[i] = 1'b1;
      end
      if (ev && evt_in.stall_sent) begin
        e.stall_sent = 1'b1;
        irq_set[i] = 1'b1;
      end
      if (ev && evt_in.nak_in) begin
        e.nak_in = 1'b1;
      end
      if (ev && evt_in.nak_out) begin
        e.nak_out = 1'b1;
      end
      if (ev && (evt_in.iso_flow || evt_in.iso_crc || evt_in.iso_flush)) begin
        irq_set[i] = 1'b1;
      end

      // ------------------------------------------------------------
      // Set strobes
      // ------------------------------------------------------------
      // Latch the written length and open a fresh count [RULE1] [RULE3]
      if (setw[B_TX_PACKET_READY] && !e.tx_packet_ready) begin
        e.tx_packet_ready = 1'b1;
        e.tx_len = e.byte_count;
        e.byte_count = 11'h000;
      end
      // A bank already on the wire cannot be killed; it completes instead
      kill_ok = setw[B_RXKL] && e.dir_in && e.tx_packet_ready && !e.in_flight;
      if (kill_ok) begin
        e.tx_packet_ready = 1'b0; // [RULE8]
        e.tx_len = 11'h000;
      end
      // Iso endpoints have no handshake, so a stall request is ignored
      if (setw[B_STALL] && !iso) begin
        e.force_stall_request = 1'b1;
      end

      // ------------------------------------------------------------
      // Clear strobes: an event in the same cycle wins, but a toggle clear beats it
      // ------------------------------------------------------------
      if (clrw[B_STALL] && !iso) begin
        e.force_stall_request = 1'b0; // [RULE9]
      end
      if (ev && evt_in.setup_rx) begin
        e.force_stall_request = 1'b0; // [RULE17]
      end
      if (clrw[B_TOGGLE]) begin
        e.data_toggle_state = PID_DATA0; // [RULE10]
      end
      if (clrw[B_RXKL] && !(ev && evt_in.out_rx)) begin
        e.rx_data_ready = 1'b0; // [RULE11]
      end
      if (clrw[B_TXCMP] && !done) begin
        e.tx_complete_flag = 1'b0; // [RULE11]
      end
      if (iso) begin // [RULE13]
        e.iso_flow_error = (e.iso_flow_error && !clrw[B_ISO_FLOW])
          || (ev && evt_in.iso_flow);
        e.crc_or_trans_count_error = (e.crc_or_trans_count_error
          && !clrw[B_ISO_CRC]) || (ev && evt_in.iso_crc);
        e.flush_error = (e.flush_error && !clrw[B_ISO_FLUSH])
          || (ev && evt_in.iso_flush);
      end else begin // [RULE12]
        e.rx_setup = (e.rx_setup && !clrw[B_SETUP])
          || (ev && evt_in.setup_rx);
        e.stall_sent = (e.stall_sent && !clrw[B_STSNT])
          || (ev && evt_in.stall_sent);
        e.nak_in = (e.nak_in && !clrw[B_NAKIN]) || (ev && evt_in.nak_in);
        e.nak_out = (e.nak_out && !clrw[B_NAKOUT])
          || (ev && evt_in.nak_out);
      end

      // Every endpoint flag is cleared by a USB bus reset
      if (usb_reset_in) begin
        e = '0;
      end
      state_next.ep[i] = e;
      // Levels for the engine, taken from the new endpoint state
      state_next.stall_ans[i] = e.force_stall_request;
      state_next.tog[i] = e.data_toggle_state[0];
    end

    // No packet may start while the bus is in reset
    if (usb_reset_in) begin
      state_next.tx.tx_start = 1'b0;
    end

    // ------------------------------------------------------------
    // Interrupt: sticky per endpoint, cleared by a completed read
    // ------------------------------------------------------------
    // Cleared at the accepting edge; an event of the wait-state cycle is cleared unread
    irq_clr = (rd_go && address_in == ADDR_IRQ_STA) ? '1 : '0;
    sta_next = (state_reg.irq_sta & ~irq_clr) | irq_set;
    state_next.irq_sta = sta_next;
    state_next.irq = |(sta_next & state_next.irq_mask);
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= '0;
      // Waitrequest stands high in reset so no request is taken early
      state_reg.wait_q <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register
  assign readdata_out = state_reg.rdata;
  assign waitrequest_out = state_reg.wait_q;
  assign tx_out = state_reg.tx;
  assign stall_answer_out = state_reg.stall_ans;
  assign toggle_lsb_out = state_reg.tog;
  assign irq_out = state_reg.irq;

endmodule

// ### sim/ess_host_model.sv
// Host-side model: answers each packet the block starts with an ack event, or a sent event for iso.
// Assumes the bench injects its own events only while no ack is pending.
`timescale 1ns/100ps
module ess_host_model
  import ess_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire ess_evt_t inj_in,
  input wire logic iso_in,
  input wire logic [3:0] delay_in,
  input wire ess_tx_t tx_in,
  output ess_evt_t evt_out
);
  logic pend_reg;
  logic [3:0] cnt_reg;
  logic [2:0] ep_reg;
  // Acks only follow a packet the device really started
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pend_reg <= 1'b0;
      cnt_reg <= 4'h0;
      ep_reg <= 3'h0;
    end else if (tx_in.tx_start) begin
      pend_reg <= 1'b1;
      cnt_reg <= delay_in;
      ep_reg <= tx_in.ep;
    end else if (pend_reg && cnt_reg == 4'h0 && !inj_in.valid) begin
      pend_reg <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
  // Iso packets get no handshake, only a sent event
  always_comb begin
    evt_out = inj_in;
    if (!inj_in.valid && pend_reg && cnt_reg == 4'h0) begin
      evt_out = '0;
      evt_out.valid = 1'b1;
      evt_out.ep = ep_reg;
      evt_out.in_ack = !iso_in;
      evt_out.in_sent = iso_in;
    end
  end
endmodule

// ### sim/ess_top_monitor.sv
// Port checker for ess_top, bound into every instance of it.
// Assumes one clock and reset_in synchronous, active high.
`timescale 1ns/100ps
module ess_top_monitor
  import ess_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic usb_reset_in,
  input wire logic [7:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [31:0] readdata_out,
  input wire logic waitrequest_out,
  input wire ess_evt_t evt_in,
  input wire ess_tx_t tx_out,
  input wire logic [NUM_EP-1:0] stall_answer_out,
  input wire logic [NUM_EP-1:0] toggle_lsb_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  logic wr_acc;
  logic clr_hit;
  assign wr_acc = write_in && !waitrequest_out && address_in[7:5] != 3'h7;
  assign clr_hit = wr_acc && address_in[4:0] == OFF_CLR;

  a_bus_answer: assert property (
    (read_in || write_in) && waitrequest_out |=> !waitrequest_out ##1
    waitrequest_out) else $error("waitrequest not low for one cycle");
  a_bus_idle: assert property (
    !read_in && !write_in |=> waitrequest_out)
    else $error("answer without request");
  a_tx_cause: assert property (
    tx_out.tx_start |-> $past(evt_in.valid && evt_in.in_token) &&
    tx_out.ep == $past(evt_in.ep)) else $error("packet without token");
  a_zlp_len: assert property (
    tx_out.tx_start |-> tx_out.zlp == (tx_out.len == 11'h0))
    else $error("zero length flag wrong");
  a_stall_drop: assert property (
    clr_hit && writedata_in[B_STALL] |=>
    !stall_answer_out[$past(address_in[7:5])]) else $error("stall kept");
  a_setup_drop: assert property (
    evt_in.valid && evt_in.setup_rx && evt_in.ep != 3'h7 && !wr_acc |=>
    !stall_answer_out[$past(evt_in.ep)]) else $error("stall after setup");
  a_toggle_zero: assert property (
    clr_hit && writedata_in[B_TOGGLE] && !evt_in.valid |=>
    !toggle_lsb_out[$past(address_in[7:5])]) else $error("toggle kept");
  a_zero_keep: assert property (
    wr_acc && writedata_in == 32'h0 && !evt_in.valid && !usb_reset_in &&
    (address_in[4:0] == OFF_SET || address_in[4:0] == OFF_CLR) |=>
    $stable(stall_answer_out) && $stable(toggle_lsb_out))
    else $error("zero write changed state");

  c_tx_start: cover property (tx_out.tx_start);
  c_irq_up: cover property ($rose(irq_out));
  c_setup: cover property (evt_in.valid && evt_in.setup_rx);
endmodule

bind ess_top ess_top_monitor u_ess_top_monitor (.clk_in(clk_in),
  .reset_in(reset_in), .usb_reset_in(usb_reset_in), .address_in(address_in),
  .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
  .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
  .evt_in(evt_in), .tx_out(tx_out), .stall_answer_out(stall_answer_out),
  .toggle_lsb_out(toggle_lsb_out), .irq_out(irq_out));

// ### sim/ess_top_test.sv
// Self-checking bench for ess_top with the host model on the engine port.
// Assumes the monitor is bound in; expectations queue for the watcher.
`timescale 1ns/100ps
module ess_top_test;
  import ess_pkg::*;
  logic clk_in = 0, reset_in = 1, usb_reset_in = 0;
  logic read_in = 0, write_in = 0, iso_q = 0, waitrequest_out, irq_out;
  logic [7:0] address_in = 0;
  logic [31:0] writedata_in = 0, readdata_out;
  logic [3:0] dly = 0;
  logic [NUM_EP-1:0] stall_answer_out, toggle_lsb_out;
  ess_evt_t evt_in, inj = '0;
  ess_tx_t tx_out;
  int err_total = 0, checks = 0;
  logic [31:0] exp_q[$], msk_q[$];
  `define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %s exp %h got %h", n, e, a); end end

  initial forever #2 clk_in = ~clk_in;
  ess_top u_ess_top (.clk_in(clk_in), .reset_in(reset_in),
    .usb_reset_in(usb_reset_in), .address_in(address_in), .read_in(read_in),
    .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out),
    .evt_in(evt_in), .tx_out(tx_out), .stall_answer_out(stall_answer_out),
    .toggle_lsb_out(toggle_lsb_out), .irq_out(irq_out));
  ess_host_model u_ess_host_model (.clk_in(clk_in), .reset_in(reset_in),
    .inj_in(inj), .iso_in(iso_q), .delay_in(dly), .tx_in(tx_out),
    .evt_out(evt_in));

  task automatic final_report;
    if (exp_q.size() != 0) err_total++;
    if (err_total == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    address_in <= a;
    writedata_in <= d;
    write_in <= w;
    read_in <= !w;
    do @(posedge clk_in);
    while (waitrequest_out !== 1'b0);
    read_in <= 1'b0;
    write_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    bus(1'b0, a, 32'h0);
  endtask
  function automatic logic [7:0] ad(input int ep, input logic [4:0] off);
    return {3'(ep), off};
  endfunction
  function automatic ess_evt_t mk(input int ep);
    mk = '0;
    mk.valid = 1'b1;
    mk.ep = 3'(ep);
  endfunction
  task automatic ev(input ess_evt_t e);
    inj <= e;
    @(posedge clk_in);
    inj <= '0;
    @(posedge clk_in);
  endtask
  // Token; when a packet is due, wait for the host model's answer
  task automatic tok(input int ep, input logic x, input int len,
                     input logic [1:0] pid);
    ess_evt_t e;
    int n;
    e = mk(ep);
    e.in_token = 1'b1;
    n = 0;
    if (x) begin
      exp_q.push_back({15'h0, 3'(ep), 11'(len), len == 0, pid});
      msk_q.push_back('1);
    end
    ev(e);
    while (x && n < 40 && !(evt_in.valid && (evt_in.in_ack || evt_in.in_sent)))
    begin @(posedge clk_in); n++; end
    if (n >= 40) err_total++;
    repeat (2) @(posedge clk_in);
  endtask
  task automatic take(input logic [31:0] v);
    logic [31:0] m;
    logic [31:0] e;
    if (exp_q.size() == 0) begin
      err_total++;
      $display("ERROR result exp none got %h", v);
    end else begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK("result", e, v & m)
    end
  endtask
  always @(posedge clk_in) begin
    if (read_in && waitrequest_out === 1'b0) take(readdata_out);
    if (tx_out.tx_start === 1'b1)
      take({15'h0, tx_out.ep, tx_out.len, tx_out.zlp, tx_out.pid});
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    final_report;
  end

  initial begin
    int n, i;
    ess_evt_t e;
    void'($urandom(93));
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    @(posedge clk_in);
    rd(8'h08, 32'h0, '1);
    rd(ad(1, OFF_SET), 32'h0, '1);
    rd(ad(1, OFF_CLR), 32'h0, '1);
    // ----------------------------------------
    // Bulk IN on endpoint 1: data, zlp, kill
    // ----------------------------------------
    bus(1'b1, ad(1, OFF_CFG), 32'h0000000a);
    bus(1'b1, 8'he4, 32'h00000002);
    tok(1, 1'b0, 0, PID_DATA0);
    n = 1 + $urandom % 6;
    for (i = 0; i < n; i++) begin
      e = mk(1);
      e.fifo_wr = 1'b1;
      ev(e);
    end
    rd(ad(1, OFF_STA), 32'(n) << B_COUNT, 32'h7ff00800);
    bus(1'b1, ad(1, OFF_SET), 32'h1 << B_TX_PACKET_READY);
    rd(ad(1, OFF_STA), 32'h00040800, 32'h7ffc0800);
    dly <= 4'($urandom % 8);
    tok(1, 1'b1, n, PID_DATA0);
    rd(ad(1, OFF_STA), 32'h00000440, 32'h00000cc0);
    `CHK("irq", 1'b1, irq_out)
    rd(8'he0, 32'h2, 32'h7f);
    bus(1'b1, ad(1, OFF_CLR), 32'h0);
    rd(ad(1, OFF_STA), 32'h00000440, 32'h00000cc0);
    `CHK("irq", 1'b0, irq_out)
    bus(1'b1, ad(1, OFF_CLR), (32'h1 << B_TXCMP) | (32'h1 << B_TOGGLE));
    rd(ad(1, OFF_STA), 32'h0, 32'h00000cc0);
    bus(1'b1, ad(1, OFF_SET), 32'h1 << B_TX_PACKET_READY);
    tok(1, 1'b1, 0, PID_DATA0);
    for (i = 0; i < 2; i++) begin
      e = mk(1);
      e.fifo_wr = 1'b1;
      ev(e);
    end
    bus(1'b1, ad(1, OFF_SET), 32'h1 << B_TX_PACKET_READY);
    bus(1'b1, ad(1, OFF_SET), 32'h1 << B_RXKL);
    rd(ad(1, OFF_STA), 32'h0, 32'h00000800);
    tok(1, 1'b0, 0, PID_DATA0);
    // ----------------------------------------
    // Control endpoint 2: stall and event flags; endpoint 4 stall per type
    // ----------------------------------------
    bus(1'b1, ad(2, OFF_CFG), 32'h0);
    bus(1'b1, ad(2, OFF_SET), 32'h1 << B_STALL);
    `CHK("stall", 1'b1, stall_answer_out[2])
    bus(1'b1, ad(2, OFF_CLR), 32'h1 << B_STALL);
    `CHK("stall", 1'b0, stall_answer_out[2])
    bus(1'b1, ad(2, OFF_SET), 32'h1 << B_STALL);
    for (i = 9; i < 16; i++) if (i != 10 && i != 11) begin
      e = mk(2);
      e.out_rx = (i == 9);
      e.setup_rx = (i == 12);
      e.stall_sent = (i == 13);
      e.nak_in = (i == 14);
      e.nak_out = (i == 15);
      ev(e);
      if (i == 12) `CHK("stall", 1'b0, stall_answer_out[2])
      rd(ad(2, OFF_STA), 32'h1 << i, 32'h1 << i);
      bus(1'b1, ad(2, OFF_CLR), 32'h1 << i);
      rd(ad(2, OFF_STA), 32'h0, 32'h1 << i);
    end
    for (i = 0; i < 4; i++) begin
      bus(1'b1, ad(4, OFF_CFG), 32'(i));
      bus(1'b1, ad(4, OFF_SET), 32'h1 << B_STALL);
      `CHK("stall", logic'(i != 1), stall_answer_out[4])
      bus(1'b1, ad(4, OFF_CLR), 32'h1 << B_STALL);
    end
    // ----------------------------------------
    // Iso IN on the last endpoint
    // ----------------------------------------
    bus(1'b1, ad(6, OFF_CFG), 32'h00000009);
    for (i = 12; i < 15; i++) begin
      e = mk(6);
      e.iso_flow = (i == 12);
      e.iso_crc = (i == 13);
      e.iso_flush = (i == 14);
      ev(e);
      rd(ad(6, OFF_STA), 32'h1 << i, 32'h1 << i);
      bus(1'b1, ad(6, OFF_CLR), 32'h1 << i);
      rd(ad(6, OFF_STA), 32'h0, 32'h1 << i);
    end
    iso_q <= 1'b1;
    bus(1'b1, ad(6, OFF_SET), 32'h1 << B_TX_PACKET_READY);
    tok(6, 1'b1, 0, PID_DATA0);
    rd(ad(6, OFF_STA), 32'h00000400, 32'h00000c00);
    usb_reset_in <= 1'b1;
    @(posedge clk_in);
    usb_reset_in <= 1'b0;
    @(posedge clk_in);
    rd(ad(6, OFF_STA), 32'h0, '1);
    final_report;
  end
endmodule
